// ### hdl/level_watch.sv
// How it works
// - Update bit copies selected statistic, then self-clears
// - Selection code 001 shows peak; default 001
// - 20-bit result over three read-only bytes
// - 8-bit frame counter counts period expiries
// - Set input-select bit 1 adds the peak to frame
// - Select bit 1 inserts peak; resets to one
// - 24-bit period in clocks, bit 0 ignored
// - Armed sync uses next SYSREF edge, then disarms
`timescale 1ns/100ps
`default_nettype none
`include "level_watch_consts.svh"

module level_watch
#(
  parameter int SAMPLE_W = 8                 // Converter sample width
)
(
  input  wire logic                  clk_sys,      // Converter output clock
  input  wire logic                  reset_n,      // Async reset, active low
  input  wire logic                  csb_n,        // Serial port select pin
  input  wire logic                  sclk,         // Serial port clock pin
  input  wire logic                  sdio_in,      // Serial data pin, input side
  output logic                       sdio_out,     // Serial data pin, output side
  output logic                       sdio_oe_n,    // Serial data drive, active low
  input  wire logic                  sysref,       // Link SYSREF pin
  input  wire logic [SAMPLE_W-1:0]   sample_data,  // Twos complement samples
  output logic                       frame_valid,  // Status frame strobe
  output level_watch_pkg::result_t   frame_peak,   // Peak field of frame
  output logic [7:0]                 frame_count   // Frame counter in frame
);
  import level_watch_pkg::*;

  reg_access_if bus ();

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [2:0]          result_sel_reg;
  logic [23:0]         period_reg;
  logic                sync_arm_reg;
  logic                framer_en_reg;
  logic                sel_peak_reg;
  result_t             result_reg;
  logic [7:0]          frame_cnt_reg;
  logic [23:0]         period_cnt_reg;
  logic [SAMPLE_W-1:0] peak_run_reg;
  logic [SAMPLE_W-1:0] peak_hold_reg;
  logic [2:0]          sysref_sync_reg;
  logic                frame_valid_reg;
  result_t             frame_peak_reg;
  logic [7:0]          frame_count_reg;

  // Magnitude of a twos complement sample; the most negative code maps cleanly
  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
    magnitude = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
  endfunction

  // Statistic chosen by a selection code; unused codes read zero
  function automatic result_t pick_stat(input logic [2:0] sel, input logic [SAMPLE_W-1:0] pk);
    pick_stat = (sel == `SEL_PEAK_CODE) ? result_t'(pk) : '0;
  endfunction

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire wr_sync   = bus.wr_stb && bus.addr == `OFF_SYNC_CTRL;
  wire wr_per0   = bus.wr_stb && bus.addr == `OFF_PERIOD_0;
  wire wr_per1   = bus.wr_stb && bus.addr == `OFF_PERIOD_1;
  wire wr_per2   = bus.wr_stb && bus.addr == `OFF_PERIOD_2;
  wire wr_stat   = bus.wr_stb && bus.addr == `OFF_STATUS_CTRL;
  wire wr_framer = bus.wr_stb && bus.addr == `OFF_FRAMER_CTRL;
  wire wr_insel  = bus.wr_stb && bus.addr == `OFF_INPUT_SELECT;
  wire upd_req   = wr_stat && bus.wdata[`BIT_RESULT_UPDATE];

  // ****************************************************************
  // Monitor timing
  // ****************************************************************
  // Bit 0 of the period is dropped so odd settings round down
  wire [23:0] period_eff = {period_reg[23:1], 1'b0};
  wire [23:0] cnt_inc    = period_cnt_reg + 24'h00_0001;
  wire        expire     = (cnt_inc >= period_eff);
  wire        sysref_edge = sysref_sync_reg[1] & ~sysref_sync_reg[2];
  wire        resync     = sync_arm_reg && sysref_edge;
  wire [SAMPLE_W-1:0] mag      = magnitude(sample_data);
  wire [SAMPLE_W-1:0] peak_new = (mag > peak_run_reg) ? mag : peak_run_reg;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      result_sel_reg <= `RST_RESULT_SEL;
      period_reg     <= `RST_PERIOD;
      framer_en_reg  <= `RST_FRAMER_ENABLE;
      sel_peak_reg   <= `RST_INPUT_SELECT;
    end
    else
    begin
      if (wr_stat)
        result_sel_reg <= bus.wdata[2:0];
      if (wr_per0)
        period_reg[7:0] <= bus.wdata;
      if (wr_per1)
        period_reg[15:8] <= bus.wdata;
      if (wr_per2)
        period_reg[23:16] <= bus.wdata;
      if (wr_framer)
        framer_en_reg <= bus.wdata[`BIT_FRAMER_ENABLE];
      if (wr_insel)
        sel_peak_reg <= bus.wdata[`BIT_SEL_PEAK];
    end

  // Sync arm: a write that arms wins over an edge in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      sync_arm_reg <= 1'b0;
    else if (wr_sync)
      sync_arm_reg <= bus.wdata[`BIT_SYNC_ARM];
    else if (resync)
      sync_arm_reg <= 1'b0;

  // SYSREF pin synchroniser plus edge history
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      sysref_sync_reg <= 3'h0;
    else
      sysref_sync_reg <= {sysref_sync_reg[1:0], sysref};

  // ****************************************************************
  // Period counter, peak detector, frame counter
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      period_cnt_reg <= 24'h00_0000;
      peak_run_reg   <= '0;
      peak_hold_reg  <= '0;
      frame_cnt_reg  <= 8'h00;
    end
    else if (resync)
    begin
      period_cnt_reg <= 24'h00_0000;
      peak_run_reg   <= '0;
    end
    else if (expire)
    begin
      period_cnt_reg <= 24'h00_0000;
      peak_run_reg   <= '0;
      peak_hold_reg  <= peak_new;
      frame_cnt_reg  <= frame_cnt_reg + 8'h01;
    end
    else
    begin
      period_cnt_reg <= cnt_inc;
      peak_run_reg   <= peak_new;
    end

  // Result snapshot; the update bit itself is never stored
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      result_reg <= '0;
    else if (upd_req)
      result_reg <= pick_stat(bus.wdata[2:0], peak_hold_reg);

  // ****************************************************************
  // Serial status frame
  // ****************************************************************
  // Frame goes out once per expired period; fields not selected read zero
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      frame_valid_reg <= 1'b0;
      frame_peak_reg  <= '0;
      frame_count_reg <= 8'h00;
    end
    else
    begin
      frame_valid_reg <= expire && !resync && framer_en_reg;
      if (expire && !resync && framer_en_reg)
      begin
        frame_peak_reg  <= sel_peak_reg ? result_t'(peak_new) : '0;
        frame_count_reg <= frame_cnt_reg + 8'h01;
      end
    end

  assign frame_valid = frame_valid_reg;
  assign frame_peak  = frame_peak_reg;
  assign frame_count = frame_count_reg;

  // ****************************************************************
  // Read decode
  // ****************************************************************
  wire [7:0] rd_stat   = {3'h0, 1'b0, 1'b0, result_sel_reg};
  wire [7:0] rd_high   = {4'h0, result_reg[19:16]};
  logic [7:0] rd_mux;
  always_comb
  begin
    if (bus.addr == `OFF_SYNC_CTRL)          rd_mux = {7'h00, sync_arm_reg};
    else if (bus.addr == `OFF_PERIOD_0)      rd_mux = period_reg[7:0];
    else if (bus.addr == `OFF_PERIOD_1)      rd_mux = period_reg[15:8];
    else if (bus.addr == `OFF_PERIOD_2)      rd_mux = period_reg[23:16];
    else if (bus.addr == `OFF_STATUS_CTRL)   rd_mux = rd_stat;
    else if (bus.addr == `OFF_RESULT_LOW)    rd_mux = result_reg[7:0];
    else if (bus.addr == `OFF_RESULT_MID)    rd_mux = result_reg[15:8];
    else if (bus.addr == `OFF_RESULT_HIGH)   rd_mux = rd_high;
    else if (bus.addr == `OFF_FRAME_COUNT)   rd_mux = frame_cnt_reg;
    else if (bus.addr == `OFF_FRAMER_CTRL)   rd_mux = {7'h00, framer_en_reg};
    else if (bus.addr == `OFF_INPUT_SELECT)  rd_mux = {6'h00, sel_peak_reg, 1'b0};
    else                                     rd_mux = 8'h00;
  end
  assign bus.rd_data = rd_mux;

  // ****************************************************************
  // Serial register port
  // ****************************************************************
  serial_status_port u_port
  (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .csb_n     (csb_n),
    .sclk      (sclk),
    .sdio_in   (sdio_in),
    .sdio_out  (sdio_out),
    .sdio_oe_n (sdio_oe_n),
    .bus       (bus.port_side)
  );

endmodule

`default_nettype wire

// ### hdl/level_watch_consts.svh
`ifndef LEVEL_WATCH_CONSTS_SVH
`define LEVEL_WATCH_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFF_SYNC_CTRL      15'h026F
`define OFF_PERIOD_0       15'h0271
`define OFF_PERIOD_1       15'h0272
`define OFF_PERIOD_2       15'h0273
`define OFF_STATUS_CTRL    15'h0274
`define OFF_RESULT_LOW     15'h0275
`define OFF_RESULT_MID     15'h0276
`define OFF_RESULT_HIGH    15'h0277
`define OFF_FRAME_COUNT    15'h0278
`define OFF_FRAMER_CTRL    15'h0279
`define OFF_INPUT_SELECT   15'h027A

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define BIT_RESULT_UPDATE  4
`define BIT_FRAMER_ENABLE  0
`define BIT_SEL_PEAK       1
`define BIT_SYNC_ARM       0
`define SEL_PEAK_CODE      3'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_RESULT_SEL     3'h1
`define RST_PERIOD         24'h00_0080
`define RST_INPUT_SELECT   1'b1
`define RST_FRAMER_ENABLE  1'b0

// ****************************************************************
// Serial port timing counts (SCLK edges)
// ****************************************************************
`define SPI_INSTR_BITS     5'h10
`define SPI_FRAME_BITS     5'h18

`endif

// ### hdl/level_watch_pkg.sv
package level_watch_pkg;

  // Serial port phases
  typedef enum logic [2:0]
  {
    SP_IDLE  = 3'b000,
    SP_INSTR = 3'b001,
    SP_WDATA = 3'b010,
    SP_RDATA = 3'b011,
    SP_DONE  = 3'b100
  } port_phase_e;

  typedef logic [14:0] reg_addr_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [19:0] result_t;

endpackage

// ### hdl/reg_access_if.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Register access between serial port and register file
// ****************************************************************
interface reg_access_if;
  import level_watch_pkg::*;
  reg_addr_t addr;     // Byte address
  reg_byte_t wdata;    // Write data
  logic      wr_stb;   // One-cycle write strobe
  reg_byte_t rd_data;  // Read data for addr

  modport port_side (output addr, output wdata, output wr_stb, input rd_data);
  modport file_side (input addr, input wdata, input wr_stb, output rd_data);
endinterface

`default_nettype wire

// ### hdl/serial_status_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "level_watch_consts.svh"

// ****************************************************************
// Three-wire serial register port, oversampled by clk_sys
// ****************************************************************
module serial_status_port
(
  input  wire logic              clk_sys,    // System clock
  input  wire logic              reset_n,    // Async reset, active low
  input  wire logic              csb_n,      // Chip select pin
  input  wire logic              sclk,       // Serial clock pin
  input  wire logic              sdio_in,    // Data pin, input side
  output logic                   sdio_out,   // Data pin, output side
  output logic                   sdio_oe_n,  // Data pin drive, active low
  reg_access_if.port_side        bus         // Register access
);
  import level_watch_pkg::*;

  logic [2:0]  csb_sync_reg;
  logic [2:0]  sclk_sync_reg;
  logic [1:0]  sdi_sync_reg;
  port_phase_e phase_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] instr_reg;
  logic [7:0]  wshift_reg;
  logic [7:0]  rshift_reg;
  logic        wr_reg;

  // Edges seen only after the second stage; the first stage feeds nothing else
  wire         cs_active = ~csb_sync_reg[1];
  wire         sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire         sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire         sdi       = sdi_sync_reg[1];
  wire [4:0]   cnt_inc   = cnt_reg + 5'h01;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      csb_sync_reg  <= 3'h7;
      sclk_sync_reg <= 3'h0;
      sdi_sync_reg  <= 2'h0;
    end
    else
    begin
      csb_sync_reg  <= {csb_sync_reg[1:0], csb_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdio_in};
    end

  // ****************************************************************
  // Frame sequencer: 16-bit instruction, one data byte, MSB first
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      phase_reg  <= SP_IDLE;
      cnt_reg    <= 5'h00;
      instr_reg  <= 16'h0000;
      wshift_reg <= 8'h00;
      rshift_reg <= 8'h00;
      wr_reg     <= 1'b0;
    end
    else
    begin
      wr_reg <= 1'b0;
      if (!cs_active)
      begin
        phase_reg <= SP_IDLE;
        cnt_reg   <= 5'h00;
      end
      else
      begin
        case (phase_reg)
          SP_IDLE:
            phase_reg <= SP_INSTR;
          SP_INSTR:
            if (sclk_rise)
            begin
              instr_reg <= {instr_reg[14:0], sdi};
              cnt_reg   <= cnt_inc;
              if (cnt_inc == `SPI_INSTR_BITS)
              begin
                // Bit 15 high marks a read
                phase_reg <= instr_reg[14] ? SP_RDATA : SP_WDATA;
              end
            end
          SP_WDATA:
            if (sclk_rise)
            begin
              wshift_reg <= {wshift_reg[6:0], sdi};
              cnt_reg    <= cnt_inc;
              if (cnt_inc == `SPI_FRAME_BITS)
              begin
                wr_reg    <= 1'b1;
                phase_reg <= SP_DONE;
              end
            end
          SP_RDATA:
            if (sclk_rise)
            begin
              cnt_reg <= cnt_inc;
              if (cnt_inc == `SPI_FRAME_BITS)
                phase_reg <= SP_DONE;
            end
            else if (sclk_fall && cnt_reg > `SPI_INSTR_BITS)
              rshift_reg <= {rshift_reg[6:0], 1'b0};
            else if (cnt_reg == `SPI_INSTR_BITS)
              rshift_reg <= bus.rd_data;  // Address only complete after last instruction rise; reload until the rise of bit 7
          // Extra clocks before deselect are ignored
          SP_DONE:
            phase_reg <= SP_DONE;
          default:
            phase_reg <= SP_IDLE;
        endcase
      end
    end

  // Bus side and pin drive
  assign bus.addr   = instr_reg[14:0];
  assign bus.wdata  = wshift_reg;
  assign bus.wr_stb = wr_reg;
  assign sdio_out   = rshift_reg[7];
  assign sdio_oe_n  = ~(cs_active && phase_reg == SP_RDATA);

endmodule

`default_nettype wire

// ### verif/level_watch_chk.sv
`timescale 1ns/100ps
`default_nettype none

// ****
// Port checks for the monitor block
// ****
module level_watch_chk
#(
  parameter int SAMPLE_W = 8                     // Sample width
)
(
  input wire logic                    clk_sys,     // Clock
  input wire logic                    reset_n,     // Reset, active low
  input wire logic                    csb_n,       // Port select
  input wire logic                    sclk,        // Serial clock
  input wire logic                    sdio_in,     // Serial in
  input wire logic                    sdio_out,    // Serial out
  input wire logic                    sdio_oe_n,   // Drive, active low
  input wire logic                    sysref,      // SYSREF pin
  input wire logic [SAMPLE_W-1:0]     sample_data, // Samples
  input wire logic                    frame_valid, // Frame strobe
  input wire level_watch_pkg::result_t frame_peak, // Peak field
  input wire logic [7:0]              frame_count  // Count field
);
  import level_watch_pkg::*;
  logic       sclk_q;
  logic [4:0] rise_cnt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Rises since reset; no write to enable the framer can land before 24
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_q   <= 1'b0;
      rise_cnt <= 5'h00;
    end
    else
    begin
      sclk_q <= sclk;
      if (sclk && !sclk_q && rise_cnt != 5'h1F)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end

  // Named steps of the port behaviour
  sequence s_idle;
    csb_n [*5];
  endsequence
  sequence s_held;
    (!sdio_oe_n && sclk) [*6];
  endsequence

  reset_out_a: assert property ($rose(reset_n) |-> !frame_valid && frame_count == 8'h00 && sdio_oe_n)
    else $error("outputs not idle after reset");
  count_step_a: assert property ($changed(frame_count) |-> frame_valid)
    else $error("frame count moved without a frame");
  peak_step_a: assert property ($changed(frame_peak) |-> frame_valid)
    else $error("frame peak moved without a frame");
  peak_range_a: assert property (frame_valid |-> frame_peak <= 20'h0_0080)
    else $error("frame peak out of range");
  no_early_a: assert property (rise_cnt < 5'h18 |-> !frame_valid)
    else $error("frame sent while framer disabled");
  drive_release_a: assert property (s_idle |-> sdio_oe_n)
    else $error("data pin driven while deselected");
  drive_start_a: assert property ($fell(sdio_oe_n) |-> $past(csb_n, 3) == 1'b0)
    else $error("data pin driven without select");
  bit_hold_a: assert property (s_held |-> $stable(sdio_out))
    else $error("read bit changed while clock high");
endmodule

bind level_watch level_watch_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
  .sysref(sysref), .sample_data(sample_data), .frame_valid(frame_valid), .frame_peak(frame_peak),
  .frame_count(frame_count));

`default_nettype wire

// ### verif/level_watch_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ****
// Bench for the monitor block
// ****
module level_watch_tb_top;
  import level_watch_pkg::*;
  logic       clk_sys, reset_n, csb_n, sclk, sdio_in, sdio_out, sdio_oe_n, sysref, frame_valid;
  logic [7:0] sample_data, frame_count;
  result_t    frame_peak;
  int         err_count, compares, cyc, fv_n;

  level_watch #(.SAMPLE_W(8)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .csb_n(csb_n), .sclk(sclk),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sysref(sysref),
    .sample_data(sample_data), .frame_valid(frame_valid), .frame_peak(frame_peak), .frame_count(frame_count));

  // Clock, 100 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Cycle stamp and frame tally
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (frame_valid === 1'b1)
      fv_n <= fv_n + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One frame; phases of 8 clocks, four times the port's synchroniser lag
  task automatic xfer(input logic rd, input reg_addr_t a, input reg_byte_t wd, output reg_byte_t rv);
    logic [23:0] w;
    w = {rd, a, wd};
    rv = 8'h00;
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdio_in = (rd && i < 8) ? 1'b0 : w[i];
      tick(8);
      if (rd && i < 8)
      begin
        rv[i] = sdio_out;
        check("sdio_oe_n", 24'(sdio_oe_n), 24'h00_0000);
      end
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
    end
    tick(8);
    csb_n = 1'b1;
    tick(8);
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    reg_byte_t x;
    xfer(1'b0, a, d, x);
  endtask

  task automatic rd_chk(input string what, input reg_addr_t a, input reg_byte_t exp);
    reg_byte_t x;
    xfer(1'b1, a, 8'h00, x);
    check(what, 24'(x), 24'(exp));
  endtask

  // Bounded wait for the next frame strobe
  task automatic wait_frame(output int at);
    at = -1;
    for (int n = 0; n < 3000 && at < 0; n++)
    begin
      tick(1);
      if (frame_valid === 1'b1)
        at = cyc;
    end
    check("frame_seen", 24'(at < 0), 24'h00_0000);
  endtask

  // Reset values; frame counter runs freely, so its byte is skipped
  task automatic t_reset;
    reg_byte_t exp [12] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
    for (int i = 0; i < 12; i++)
      if (i != 9)
        rd_chk("reset_value", 15'h026F + 15'(i), exp[i]);
    check("frames_off", 24'(fv_n), 24'h00_0000);
    $display("Test reset done");
  endtask

  task automatic t_update;
    wr(15'h0274, 8'h11);
    rd_chk("result_low", 15'h0275, 8'h64);
    rd_chk("result_mid", 15'h0276, 8'h00);
    rd_chk("result_high", 15'h0277, 8'h00);
    rd_chk("update_clear", 15'h0274, 8'h01);
    wr(15'h0275, 8'hFF);
    wr(15'h0300, 8'hFF);
    rd_chk("ro_write", 15'h0275, 8'h64);
    rd_chk("unmapped", 15'h0300, 8'h00);
    wr(15'h0274, 8'h12);
    rd_chk("other_sel", 15'h0275, 8'h00);
    sample_data = 8'h80;
    wr(15'h0274, 8'h11);
    rd_chk("peak_max", 15'h0275, 8'h80);
    $display("Test update done");
  endtask

  task automatic t_frames;
    int         t0, t1;
    logic [7:0] c0;
    wr(15'h0271, 8'h21);
    wr(15'h0279, 8'h01);
    wait_frame(t0);
    c0 = frame_count;
    wait_frame(t1);
    check("period", 24'(t1 - t0), 24'h00_0020);
    check("count_step", 24'(frame_count), 24'(8'(c0 + 8'h01)));
    check("peak_field", 24'(frame_peak), 24'h00_0080);
    wr(15'h027A, 8'h00);
    wait_frame(t0);
    check("peak_off", 24'(frame_peak), 24'h00_0000);
    rd_chk("sel_bit", 15'h027A, 8'h00);
    $display("Test frames done");
  endtask

  // Armed edge restarts the period; the later, unarmed one must not
  task automatic t_sync;
    int t0, t1;
    wr(15'h026F, 8'h01);
    rd_chk("arm_set", 15'h026F, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      wait_frame(t0);
      tick(10);
      sysref = 1'b1;
      tick(2);
      sysref = 1'b0;
      wait_frame(t1);
      check("sync_restart", 24'(t1 - t0 == 32), 24'(k));
    end
    rd_chk("arm_clear", 15'h026F, 8'h00);
    $display("Test sync done");
  endtask

  task automatic give_verdict;
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog, about three times the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    give_verdict;
  end

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    csb_n = 1'b1;
    sclk = 1'b0;
    sdio_in = 1'b0;
    sysref = 1'b0;
    sample_data = 8'h9C;
    err_count = 0;
    compares = 0;
    tick(8);
    reset_n = 1'b1;
    tick(2);
    t_reset;
    t_update;
    t_frames;
    t_sync;
    give_verdict;
  end
endmodule

`default_nettype wire
